//--- src/regxfer_defs.svh
// opcodes, field positions, reset values and cycle counts for the transfer executor
`ifndef REGXFER_DEFS_SVH
`define REGXFER_DEFS_SVH
// instruction word layout
`define RX_WORD_W 10
`define RX_IMM_MSB 3
`define RX_HI_LSB 4
// upper six bits of the exchange-and-increment opcode
`define RX_OPC_XCHG_HI 6'h2e
// full ten-bit opcodes of the register transfers
`define RX_OPC_B_TO_A 10'h01e
`define RX_OPC_A_TO_B 10'h00e
`define RX_OPC_Y_TO_A 10'h01f
`define RX_OPC_A_TO_Y 10'h00c
`define RX_OPC_PACK 10'h01a
`define RX_OPC_UNPACK 10'h02a
`define RX_OPC_A_TO_DIR 10'h029
`define RX_OPC_DIR_TO_A 10'h051
// reset values
`define RX_RST_NIBBLE 4'h0
`define RX_RST_WIDE 8'h00
`define RX_RST_DIR 3'h0
// every instruction of the group takes one word and one cycle
`define RX_EXEC_WORDS 1
`define RX_EXEC_CYCLES 1
`endif

//--- src/regxfer_pkg.sv
// types shared by the transfer executor and its decoder
`default_nettype none
package regxfer_pkg;
  typedef enum logic [9:0] {
    OP_NONE      = 10'h001,
    OP_XCHG_INC  = 10'h002,
    OP_B_TO_A    = 10'h004,
    OP_A_TO_B    = 10'h008,
    OP_Y_TO_A    = 10'h010,
    OP_A_TO_Y    = 10'h020,
    OP_PACK      = 10'h040,
    OP_UNPACK    = 10'h080,
    OP_A_TO_DIR  = 10'h100,
    OP_DIR_TO_A  = 10'h200
  } op_t;

  typedef struct packed {
    logic [3:0] a;
    logic [3:0] b;
    logic [3:0] x;
    logic [3:0] y;
    logic [7:0] e;
    logic [2:0] dir;
  } regs_t;

  typedef struct packed {
    logic we;
    logic [3:0] addr_x;
    logic [3:0] addr_y;
    logic [3:0] data;
  } ram_wr_t;

  typedef struct packed {
    regs_t regs;
    ram_wr_t wr;
    logic skip;
    logic done;
  } state_t;
endpackage
`default_nettype wire

//--- src/xfer_decode.sv
// opcode decoder for the transfer group
`timescale 1ns/10ps
`default_nettype none
`include "regxfer_defs.svh"
module xfer_decode (
  // instruction word
  input wire logic [9:0] instr,
  // decoded operation and immediate
  output var regxfer_pkg::op_t op,
  output logic [3:0] imm
);
  import regxfer_pkg::*;

  always_comb begin
    imm = instr[`RX_IMM_MSB:0];
    op = OP_NONE;
    if (instr[9:`RX_HI_LSB] == `RX_OPC_XCHG_HI) begin
      op = OP_XCHG_INC; // RULE4
    end else begin
      unique case (instr)
        `RX_OPC_B_TO_A: op = OP_B_TO_A;
        `RX_OPC_A_TO_B: op = OP_A_TO_B;
        `RX_OPC_Y_TO_A: op = OP_Y_TO_A;
        `RX_OPC_A_TO_Y: op = OP_A_TO_Y;
        `RX_OPC_PACK: op = OP_PACK;
        `RX_OPC_UNPACK: op = OP_UNPACK;
        `RX_OPC_A_TO_DIR: op = OP_A_TO_DIR;
        `RX_OPC_DIR_TO_A: op = OP_DIR_TO_A;
        // words of other groups are executed elsewhere
        default: op = OP_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- src/register_transfer_exec.sv
// execution of the exchange-and-increment instruction and register transfers
// Function
// RULE1: exchange swaps accumulator with the RAM nibble at the data pointer.
// RULE2: exchange replaces pointer X with X xor the four-bit immediate.
// RULE3: exchange increments Y modulo sixteen; zero result skips the next instruction.
// RULE4: exchange opcode is upper bits 101110, immediate low; one word, one cycle.
// RULE5: simple transfers copy B to A, A to B, Y to A, A to Y.
// RULE6: pack loads wide register high nibble from B, low nibble from A.
// RULE7: unpack copies wide high nibble to B, low to A; wide unchanged.
// RULE8: accumulator-to-direction writes A low three bits; A msb ignored.
// RULE9: direction-to-accumulator puts direction in A low bits, msb cleared.
// RULE10: transfers take one cycle, one word, never touch carry, never skip.
// RULE11: skipped word is fetched but all its side effects are suppressed.
`timescale 1ns/10ps
`default_nettype none
`include "regxfer_defs.svh"
module register_transfer_exec (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  // instruction from the sequencer
  input wire logic INSTR_VALID,
  input wire logic [9:0] INSTR,
  // data RAM read port, addressed by REGS.x and REGS.y
  input wire logic [3:0] RAM_RDATA,
  // register file and RAM write port
  output var regxfer_pkg::regs_t REGS,
  output var regxfer_pkg::ram_wr_t RAM_WR,
  // status toward the sequencer
  output logic SKIP_PENDING,
  output logic EXEC_DONE
);
  import regxfer_pkg::*;

  state_t s_r;
  state_t s_nxt;
  op_t op;
  logic [3:0] imm;
  logic [3:0] mem_rd;
  logic [3:0] y_inc;
  logic take;

  xfer_decode u_decode (
    .instr(INSTR),
    .op(op),
    .imm(imm)
  );

  // the RAM write lands one cycle late; forward it so a back-to-back
  // exchange at the same address reads the nibble just written
  always_comb begin
    if (s_r.wr.we && s_r.wr.addr_x == s_r.regs.x && s_r.wr.addr_y == s_r.regs.y) begin
      mem_rd = s_r.wr.data;
    end else begin
      mem_rd = RAM_RDATA;
    end
  end

  assign y_inc = s_r.regs.y + 4'h1;
  assign take = INSTR_VALID && !s_r.skip;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = INSTR_VALID;
    s_nxt.wr.we = 1'b0;
    if (INSTR_VALID && s_r.skip) begin
      // fetched as a no-operation cycle
      s_nxt.skip = 1'b0; // RULE11
    end else if (take) begin
      s_nxt.skip = 1'b0; // RULE10
      unique case (op)
        OP_XCHG_INC: begin
          s_nxt.regs.a = mem_rd; // RULE1
          s_nxt.wr.we = 1'b1; // RULE1
          s_nxt.wr.addr_x = s_r.regs.x;
          s_nxt.wr.addr_y = s_r.regs.y;
          s_nxt.wr.data = s_r.regs.a; // RULE1
          s_nxt.regs.x = s_r.regs.x ^ imm; // RULE2
          s_nxt.regs.y = y_inc; // RULE3
          s_nxt.skip = (y_inc == 4'h0); // RULE3
        end
        OP_B_TO_A: s_nxt.regs.a = s_r.regs.b; // RULE5
        OP_A_TO_B: s_nxt.regs.b = s_r.regs.a; // RULE5
        OP_Y_TO_A: s_nxt.regs.a = s_r.regs.y; // RULE5
        OP_A_TO_Y: s_nxt.regs.y = s_r.regs.a; // RULE5
        OP_PACK: s_nxt.regs.e = {s_r.regs.b, s_r.regs.a}; // RULE6
        OP_UNPACK: begin
          s_nxt.regs.b = s_r.regs.e[7:4]; // RULE7
          s_nxt.regs.a = s_r.regs.e[3:0]; // RULE7
        end
        OP_A_TO_DIR: s_nxt.regs.dir = s_r.regs.a[2:0]; // RULE8
        OP_DIR_TO_A: s_nxt.regs.a = {1'b0, s_r.regs.dir}; // RULE9
        // other groups: nothing changes here
        OP_NONE: s_nxt.regs = s_r.regs;
        default: s_nxt.regs = s_r.regs;
      endcase
    end
  end

  // no carry is held here, so no transfer can disturb it
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_r.regs.a <= `RX_RST_NIBBLE;
      s_r.regs.b <= `RX_RST_NIBBLE;
      s_r.regs.x <= `RX_RST_NIBBLE;
      s_r.regs.y <= `RX_RST_NIBBLE;
      s_r.regs.e <= `RX_RST_WIDE;
      s_r.regs.dir <= `RX_RST_DIR;
      s_r.wr.we <= 1'b0;
      s_r.wr.addr_x <= `RX_RST_NIBBLE;
      s_r.wr.addr_y <= `RX_RST_NIBBLE;
      s_r.wr.data <= `RX_RST_NIBBLE;
      s_r.skip <= 1'b0;
      s_r.done <= 1'b0;
    end else if (CLK_EN) begin
      s_r <= s_nxt; // RULE10
    end
  end

  assign REGS = s_r.regs;
  assign RAM_WR = s_r.wr;
  assign SKIP_PENDING = s_r.skip;
  assign EXEC_DONE = s_r.done;

  // checks
  logic go;
  assign go = CLK_EN && take;

  property p_xchg_acc;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op == OP_XCHG_INC |=> REGS.a == $past(mem_rd);
  endproperty
  a_xchg_acc: assert property (p_xchg_acc) else $error("exchange lost memory nibble"); // RULE1

  property p_xchg_mem;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op == OP_XCHG_INC |=> RAM_WR.we && RAM_WR.data == $past(REGS.a)
        && RAM_WR.addr_x == $past(REGS.x) && RAM_WR.addr_y == $past(REGS.y);
  endproperty
  a_xchg_mem: assert property (p_xchg_mem) else $error("exchange wrote wrong nibble"); // RULE1

  property p_xor;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op == OP_XCHG_INC |=> REGS.x == ($past(REGS.x) ^ $past(INSTR[3:0]));
  endproperty
  a_xor: assert property (p_xor) else $error("pointer X not xored"); // RULE2

  property p_inc_skip;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op == OP_XCHG_INC |=> REGS.y == $past(REGS.y) + 4'h1
        && SKIP_PENDING == ($past(REGS.y) == 4'hf);
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("Y increment or skip wrong"); // RULE3

  property p_skip_nop;
    @(posedge REF_CLK) disable iff (!RESET_N)
      CLK_EN && INSTR_VALID && SKIP_PENDING |=> $stable(REGS) && !RAM_WR.we && !SKIP_PENDING;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skipped word had effect"); // RULE11

  property p_no_skip;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op != OP_XCHG_INC |=> !SKIP_PENDING && !RAM_WR.we && EXEC_DONE;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("transfer caused skip or write"); // RULE10

  property p_copy;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op == OP_A_TO_B ##1 CLK_EN && take && op == OP_B_TO_A
        |=> REGS.a == $past(REGS.a, 2) && REGS.b == $past(REGS.a, 2);
  endproperty
  a_copy: assert property (p_copy) else $error("A and B copies disagree"); // RULE5

  property p_pack;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op == OP_PACK |=> REGS.e == {$past(REGS.b), $past(REGS.a)};
  endproperty
  a_pack: assert property (p_pack) else $error("pack wrong"); // RULE6

  property p_unpack;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op == OP_UNPACK |=> $stable(REGS.e) && {REGS.b, REGS.a} == REGS.e;
  endproperty
  a_unpack: assert property (p_unpack) else $error("unpack wrong"); // RULE7

  property p_dir_in;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op == OP_A_TO_DIR |=> REGS.dir == $past(REGS.a[2:0]);
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("direction load wrong"); // RULE8

  property p_dir_out;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op == OP_DIR_TO_A |=> REGS.a == {1'b0, $past(REGS.dir)};
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("direction read wrong"); // RULE9

  property p_done;
    @(posedge REF_CLK) disable iff (!RESET_N)
      CLK_EN && INSTR_VALID |=> EXEC_DONE;
  endproperty
  a_done: assert property (p_done) else $error("taken word not reported"); // RULE10

  property p_idle;
    @(posedge REF_CLK) disable iff (!RESET_N)
      CLK_EN && !INSTR_VALID |=> !EXEC_DONE && !RAM_WR.we && $stable(REGS);
  endproperty
  a_idle: assert property (p_idle) else $error("idle cycle had effect"); // RULE10

  property p_other;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op == OP_NONE |=> $stable(REGS) && !RAM_WR.we && !SKIP_PENDING;
  endproperty
  a_other: assert property (p_other) else $error("foreign word had effect"); // RULE4

  property p_xchg_keep;
    @(posedge REF_CLK) disable iff (!RESET_N)
      go && op == OP_XCHG_INC |=> $stable(REGS.b) && $stable(REGS.e) && $stable(REGS.dir);
  endproperty
  a_xchg_keep: assert property (p_xchg_keep) else $error("exchange touched other regs"); // RULE1

  // enable low must hold every output, pulses included
  property p_freeze;
    @(posedge REF_CLK) disable iff (!RESET_N)
      !CLK_EN |=> $stable(REGS) && $stable(RAM_WR)
        && $stable(SKIP_PENDING) && $stable(EXEC_DONE);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low"); // RULE10
endmodule
`default_nettype wire

//--- bench/ram_model.sv
// data RAM beside the executor: combinational read at the pointer, write on strobe
`timescale 1ns/10ps
`default_nettype none
module ram_model (
  // clock
  input wire logic clk,
  // pointer and write port
  input wire regxfer_pkg::regs_t regs,
  input wire regxfer_pkg::ram_wr_t wr,
  // read data
  output logic [3:0] rdata
);
  import regxfer_pkg::*;
  logic [3:0] mem [256];
  // each nibble is the inverse of the Y half of its address, so a wrong Y shows but a wrong X does not
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = ~i[3:0];
    end
  end
  assign rdata = mem[{regs.x, regs.y}];
  always @(posedge clk) begin
    if (wr.we === 1'b1) begin
      mem[{wr.addr_x, wr.addr_y}] <= wr.data;
    end
  end
endmodule
`default_nettype wire

//--- bench/test_register_transfer_exec.sv
// bench for the transfer executor: scenarios and verdict
`timescale 1ns/10ps
`default_nettype none
module test_register_transfer_exec;
  import regxfer_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic valid = 1'b0;
  logic [9:0] instr = 10'h000;
  logic [3:0] rdata;
  regs_t regs;
  ram_wr_t wr;
  logic skip;
  logic done;
  int fails = 0;
  int n_compared = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  register_transfer_exec dut (.REF_CLK(clk), .RESET_N(rst_n), .CLK_EN(clk_en),
    .INSTR_VALID(valid), .INSTR(instr), .RAM_RDATA(rdata), .REGS(regs),
    .RAM_WR(wr), .SKIP_PENDING(skip), .EXEC_DONE(done));
  ram_model ram (.clk(clk), .regs(regs), .wr(wr), .rdata(rdata));
  task check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // valid stays up so consecutive steps run back to back
  task step(input logic [9:0] i, input regs_t r, input logic s);
    instr = i;
    valid = 1'b1;
    @(posedge clk);
    #1;
    check(regs === r && skip === s && done === 1'b1, "register state after word");
  endtask
  task idle;
    valid = 1'b0;
    @(posedge clk);
    #1;
    check(done === 1'b0 && wr.we === 1'b0, "pulse held past one cycle");
  endtask
  task t_xchg;
    step(10'h2ea, regs_t'{4'hf, 4'h0, 4'ha, 4'h1, 8'h00, 3'h0}, 1'b0);
    check(wr === ram_wr_t'{1'b1, 4'h0, 4'h0, 4'h0}, "ram write of exchange");
    step(10'h01f, regs_t'{4'h1, 4'h0, 4'ha, 4'h1, 8'h00, 3'h0}, 1'b0);
    step(10'h2e0, regs_t'{4'he, 4'h0, 4'ha, 4'h2, 8'h00, 3'h0}, 1'b0);
    check(wr === ram_wr_t'{1'b1, 4'ha, 4'h1, 4'h1}, "ram write of exchange");
    step(10'h00c, regs_t'{4'he, 4'h0, 4'ha, 4'he, 8'h00, 3'h0}, 1'b0);
    step(10'h2e5, regs_t'{4'h1, 4'h0, 4'hf, 4'hf, 8'h00, 3'h0}, 1'b0);
    step(10'h00e, regs_t'{4'h1, 4'h1, 4'hf, 4'hf, 8'h00, 3'h0}, 1'b0);
    step(10'h2e0, regs_t'{4'h0, 4'h1, 4'hf, 4'h0, 8'h00, 3'h0}, 1'b1);
    // skipped exchange must neither move a pointer nor write the RAM
    step(10'h2e3, regs_t'{4'h0, 4'h1, 4'hf, 4'h0, 8'h00, 3'h0}, 1'b0);
    check(wr.we === 1'b0, "write from skipped word");
    step(10'h01e, regs_t'{4'h1, 4'h1, 4'hf, 4'h0, 8'h00, 3'h0}, 1'b0);
    idle();
  endtask
  task t_wide;
    step(10'h2e0, regs_t'{4'hf, 4'h1, 4'hf, 4'h1, 8'h00, 3'h0}, 1'b0);
    check(wr === ram_wr_t'{1'b1, 4'hf, 4'h0, 4'h1}, "ram write of exchange");
    step(10'h01a, regs_t'{4'hf, 4'h1, 4'hf, 4'h1, 8'h1f, 3'h0}, 1'b0);
    step(10'h029, regs_t'{4'hf, 4'h1, 4'hf, 4'h1, 8'h1f, 3'h7}, 1'b0);
    step(10'h051, regs_t'{4'h7, 4'h1, 4'hf, 4'h1, 8'h1f, 3'h7}, 1'b0);
    step(10'h02a, regs_t'{4'hf, 4'h1, 4'hf, 4'h1, 8'h1f, 3'h7}, 1'b0);
    // neighbouring opcodes of other groups leave everything alone
    step(10'h2d0, regs_t'{4'hf, 4'h1, 4'hf, 4'h1, 8'h1f, 3'h7}, 1'b0);
    step(10'h2f0, regs_t'{4'hf, 4'h1, 4'hf, 4'h1, 8'h1f, 3'h7}, 1'b0);
    step(10'h051, regs_t'{4'h7, 4'h1, 4'hf, 4'h1, 8'h1f, 3'h7}, 1'b0);
    // back-to-back copies in both directions
    step(10'h00e, regs_t'{4'h7, 4'h7, 4'hf, 4'h1, 8'h1f, 3'h7}, 1'b0);
    step(10'h01e, regs_t'{4'h7, 4'h7, 4'hf, 4'h1, 8'h1f, 3'h7}, 1'b0);
    idle();
  endtask
  task t_freeze;
    clk_en = 1'b0;
    instr = 10'h00e;
    valid = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(regs === regs_t'{4'h7, 4'h7, 4'hf, 4'h1, 8'h1f, 3'h7} && done === 1'b0,
      "state moved with clock disabled");
    valid = 1'b0;
    clk_en = 1'b1;
  endtask
  task end_sim;
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1;
    check(regs === '0 && wr.we === 1'b0 && skip === 1'b0 && done === 1'b0, "reset state");
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    t_xchg();
    t_wide();
    t_freeze();
    end_sim();
  end
endmodule
`default_nettype wire
